/* File: include/ers_pkg.sv */
// Purpose: constants for the emergency reset sequencer
// Assumes: system clock of 50 MHz
// Notes:   times are kept in their printed unit, counts derived
package ers_pkg;
	// ==========================================================
	// clock
	localparam int unsigned CLK_HZ             = 50000000;
	// ==========================================================
	// times in microseconds and milliseconds
	localparam int unsigned EXT_RESET_MIN_US   = 200;
	localparam int unsigned HOLD_MIN_MS        = 20;
	localparam int unsigned HOLD_TYP_MS        = 40;
	localparam int unsigned HOLD_MAX_MS        = 100;
	localparam int unsigned INIT_CANCEL_TYP_MS = 34;
	// ==========================================================
	// derived cycle counts; least time truncates, with a floor of one cycle
	localparam int unsigned EXT_RESET_MIN_CYC  =
		(EXT_RESET_MIN_US * (CLK_HZ / 1000000) + 0) < 1 ? 1 :
		EXT_RESET_MIN_US * (CLK_HZ / 1000000);
	localparam int unsigned HOLD_TYP_CYC       = HOLD_TYP_MS * (CLK_HZ / 1000);
	localparam int unsigned INIT_CANCEL_CYC    = INIT_CANCEL_TYP_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W              = 24;
	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ERS_POWER_HOLD,
		ERS_EXT_RESET,
		ERS_INIT_CANCEL,
		ERS_READY_PULSE,
		ERS_RUN,
		ERS_OFF
	} ers_state_e;
endpackage

/* File: rtl/ers_pin_filter.sv */
// Purpose: three-stage synchroniser and width filter for a pin
// Assumes: pin is asynchronous to clk_sys_i
// Notes:   low_qual_o rises only after the low level persists MIN_CYC cycles
`timescale 1ns/1ps
module ers_pin_filter #(
	parameter int unsigned MIN_CYC = 10000,
	parameter int unsigned CNT_W   = 24
) (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      low_qual_o
);
	logic             s1_q;
	logic             s2_q;
	logic             s3_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             stable_lo;
	logic             qual_d;

	// ==========================================================
	// synchroniser; level falls once stages two and three are both low
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign stable_lo = ~s2_q & ~s3_q;
	assign level_o   = ~stable_lo;

	// ==========================================================
	// width filter; short glitches never qualify
	assign cnt_d  = !stable_lo ? '0 :
	                (cnt_q == CNT_W'(MIN_CYC)) ? cnt_q : cnt_q + CNT_W'(1);
	assign qual_d = stable_lo & (cnt_d == CNT_W'(MIN_CYC));

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q      <= '0;
			low_qual_o <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			low_qual_o <= qual_d;
		end
	end
endmodule

/* File: rtl/ers_sequencer.sv */
// Purpose: reset sequencer around one open-drain active-low reset line
// Assumes: reset_i models supply power-up; pins are asynchronous
// Notes:   counts above 4096 cycles are parameters so simulation can shorten them
`timescale 1ns/1ps
// Overview of operation
// R1: reset request needs line low 200us minimum
// R2: stay in reset while line held low
// R3: power-up drives line low 20-100ms
// R4: run 34ms initialisation after any reset
// R5: signal OK readiness after sequence completes
// R6: line drives external reset only at power-up
// R7: others drive line open-drain only
// R8: application uses line only for emergencies
// R9: others avoid asserting during power-up hold
// R10: power off after reset if on-request low
// R11: filter reset input against narrow pulses
module ers_sequencer
	import ers_pkg::*;
#(
	parameter int unsigned EXT_MIN_CYC = EXT_RESET_MIN_CYC,
	parameter int unsigned HOLD_CYC    = HOLD_TYP_CYC,
	parameter int unsigned CANCEL_CYC  = INIT_CANCEL_CYC
) (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	input  wire logic reset_line_i,
	output logic      reset_line_o,
	output logic      reset_line_oe_o,
	input  wire logic power_on_req_i,
	output logic      core_reset_o,
	output logic      ready_ok_o,
	output logic      running_o,
	output logic      power_off_o
);
	ers_state_e       state_q;
	ers_state_e       state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             line_level;
	logic             line_low_qual;
	logic             on_s1_q;
	logic             on_s2_q;
	logic             on_s3_q;
	logic             on_level_q;
	logic             hold_done;
	logic             cancel_done;
	logic             st_hold;
	logic             st_ext;
	logic             st_cancel;
	logic             st_ready;
	logic             st_run;
	logic             st_off;
	logic             oe_d;
	logic             oe_q;
	logic             core_d;
	logic             core_q;
	logic             ok_d;
	logic             ok_q;
	logic             run_d;
	logic             run_q;
	logic             off_d;
	logic             off_q;

	// ==========================================================
	// reset line input conditioning
	// R11: synchronise and filter
	ers_pin_filter #(
		.MIN_CYC (EXT_MIN_CYC),
		.CNT_W   (CNT_W)
	) u_line_filter (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.pin_i      (reset_line_i),
		.level_o    (line_level),
		.low_qual_o (line_low_qual)
	);

	// ==========================================================
	// on-request pin: level changes once stages two and three agree
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			on_s1_q    <= 1'b0;
			on_s2_q    <= 1'b0;
			on_s3_q    <= 1'b0;
			on_level_q <= 1'b0;
		end else begin
			on_s1_q <= power_on_req_i;
			on_s2_q <= on_s1_q;
			on_s3_q <= on_s2_q;
			if (on_s2_q == on_s3_q) begin
				on_level_q <= on_s3_q;
			end
		end
	end

	// ==========================================================
	// sequencer
	// R3: hold counter end point
	assign hold_done   = (cnt_q == CNT_W'(HOLD_CYC - 1));
	// R4: cancel counter end point
	assign cancel_done = (cnt_q == CNT_W'(CANCEL_CYC - 1));

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		case (state_q)
			ERS_POWER_HOLD: begin
				// R3: supervisor hold time
				if (hold_done) begin
					state_d = ERS_EXT_RESET;
					cnt_d   = '0;
				end
			end
			ERS_EXT_RESET: begin
				cnt_d = '0;
				// R2: leave only once line high
				if (line_level) begin
					state_d = ERS_INIT_CANCEL;
				end
			end
			ERS_INIT_CANCEL: begin
				// R1: qualified low restarts reset
				if (line_low_qual) begin
					state_d = ERS_EXT_RESET;
					cnt_d   = '0;
				// R4: initialisation cancel period
				end else if (cancel_done) begin
					cnt_d = '0;
					// R10: off when on-request low
					state_d = on_level_q ? ERS_READY_PULSE : ERS_OFF;
				end
			end
			ERS_READY_PULSE: begin
				cnt_d   = '0;
				state_d = ERS_RUN;
			end
			ERS_RUN: begin
				cnt_d = '0;
				// R1: emergency reset request
				if (line_low_qual) begin
					state_d = ERS_EXT_RESET;
				end
			end
			ERS_OFF: begin
				cnt_d = '0;
			end
			default: begin
				state_d = ERS_POWER_HOLD;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ERS_POWER_HOLD;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ==========================================================
	// state decode
	// flat views of the state keep the output logic simple
	assign st_hold   = (state_q == ERS_POWER_HOLD);
	assign st_ext    = (state_q == ERS_EXT_RESET);
	assign st_cancel = (state_q == ERS_INIT_CANCEL);
	assign st_ready  = (state_q == ERS_READY_PULSE);
	assign st_run    = (state_q == ERS_RUN);
	assign st_off    = (state_q == ERS_OFF);

	// ==========================================================
	// output decode; pins follow the state one cycle later
	// R6: drive line low only in power-up hold
	assign oe_d   = st_hold;

	// R2: core held while line low or init runs
	assign core_d = st_hold
	                | st_ext
	                | st_cancel;

	// R5: one-cycle ready report
	assign ok_d   = st_ready;
	assign run_d  = st_run;

	// R10: off is terminal until supply reset
	assign off_d  = st_off;

	// ==========================================================
	// output flops; registered so no decode glitch reaches a pin
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			oe_q   <= 1'b1;
			core_q <= 1'b1;
			ok_q   <= 1'b0;
			run_q  <= 1'b0;
			off_q  <= 1'b0;
		end else begin
			oe_q   <= oe_d;
			core_q <= core_d;
			ok_q   <= ok_d;
			run_q  <= run_d;
			off_q  <= off_d;
		end
	end

	// ==========================================================
	// pins
	// the line is open-drain, so only a low is ever offered
	// a host driving it high would fight this pull (R7)
	assign reset_line_o    = 1'b0;
	assign reset_line_oe_o = oe_q;
	assign core_reset_o    = core_q;
	assign ready_ok_o      = ok_q;
	assign running_o       = run_q;
	assign power_off_o     = off_q;
endmodule

/* File: sim/ers_host_model.sv */
// Purpose: host that pulls the reset wire
// Assumes: the wire has a pull-up
// Notes:   only ever pulls low
`timescale 1ns/1ps
module ers_host_model (
	input  wire logic clk_sys_i,
	output logic      pull_o
);
	initial pull_o = 1'h0;
	task automatic press(input int n);
		@(posedge clk_sys_i);
		pull_o <= 1'h1;
		repeat (n) @(posedge clk_sys_i);
		pull_o <= 1'h0;
	endtask
endmodule

/* File: sim/ers_sequencer_monitor.sv */
// Purpose: port checks of the sequencer
// Assumes: bound into ers_sequencer
// Notes:   windows allow for the synchroniser
`timescale 1ns/1ps
module ers_sequencer_monitor #(
	parameter int unsigned EXT_MIN_CYC = 8,
	parameter int unsigned HOLD_CYC    = 20,
	parameter int unsigned CANCEL_CYC  = 20
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic reset_line_i,
	input wire logic reset_line_o,
	input wire logic reset_line_oe_o,
	input wire logic power_on_req_i,
	input wire logic core_reset_o,
	input wire logic ready_ok_o,
	input wire logic running_o,
	input wire logic power_off_o
);
	localparam int CMAX = CANCEL_CYC + 8;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// ==========
	// checks
	sequence s_glitch; running_o ##1 !reset_line_i [*4] ##1 reset_line_i; endsequence
	sequence s_long; running_o ##1 !reset_line_i [*8]; endsequence
	sequence s_ok; ready_ok_o ##1 (!ready_ok_o && running_o); endsequence
	hold_time_a: assert property ($fell(reset_i) |-> reset_line_oe_o [*8]
		##[1:HOLD_CYC] !reset_line_oe_o) else $error("hold");
	line_release_a: assert property (!reset_line_oe_o |=> !reset_line_oe_o)
		else $error("drive");
	drive_low_a: assert property (reset_line_oe_o |-> !reset_line_o) else $error("od");
	stay_reset_a: assert property (core_reset_o && !reset_line_i |=> core_reset_o)
		else $error("left");
	glitch_ignored_a: assert property (s_glitch |=> running_o [*8]) else $error("glitch");
	long_reset_a: assert property (s_long |-> ##[1:8] core_reset_o) else $error("long");
	cancel_time_a: assert property (core_reset_o && $rose(reset_line_i) |->
		core_reset_o [*8] ##[1:CMAX] !core_reset_o) else $error("cancel");
	ready_ok_a: assert property ($fell(core_reset_o) |-> s_ok or power_off_o)
		else $error("ok");
	off_sticky_a: assert property (power_off_o |=> power_off_o && !running_o)
		else $error("off");
endmodule
bind ers_sequencer ers_sequencer_monitor #(.EXT_MIN_CYC(EXT_MIN_CYC), .HOLD_CYC(HOLD_CYC),
	.CANCEL_CYC(CANCEL_CYC)) ers_sequencer_monitor_i (.clk_sys_i, .reset_i, .reset_line_i,
	.reset_line_o, .reset_line_oe_o, .power_on_req_i, .core_reset_o, .ready_ok_o,
	.running_o, .power_off_o);

/* File: sim/tb_emergency_reset_sequencer.sv */
// Purpose: self-checking bench of the sequencer
// Assumes: counts shortened by parameters
// Notes:   wire level built from both pulls
`timescale 1ns/1ps
module tb_emergency_reset_sequencer;
	localparam int H = 20;
	localparam int C = 20;
	logic clk_sys_i      = 1'h0;
	logic reset_i        = 1'h1;
	logic power_on_req_i = 1'h1;
	logic lo, oe, pull, core, ok, run, off;
	wire  line = !((oe && !lo) || pull);
	int   err_count = 0;
	int   checked   = 0;
	int   n;
	always #10 clk_sys_i = ~clk_sys_i;
	ers_sequencer #(.EXT_MIN_CYC(8), .HOLD_CYC(H), .CANCEL_CYC(C)) ers_sequencer_i (
		.clk_sys_i, .reset_i, .reset_line_i(line), .reset_line_o(lo),
		.reset_line_oe_o(oe), .power_on_req_i, .core_reset_o(core),
		.ready_ok_o(ok), .running_o(run), .power_off_o(off));
	ers_host_model ers_host_model_i (.clk_sys_i, .pull_o(pull));
	// ==========
	// helpers
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge clk_sys_i);
		#1;
	endtask
	// bounded wait for ok or off
	task automatic wait_end();
		n = 0;
		while (ok !== 1'h1 && off !== 1'h1 && n < 200) begin
			tick();
			n++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========
	// tests
	task automatic t_power();
		n = 0;
		while (oe === 1'h1 && n < 200) begin
			tick();
			n++;
		end
		chk("hold", 32'(n >= H - 1 && n <= H + 3), 32'h1);
		wait_end();
		chk("init", 32'(n >= C && n <= C + 8), 32'h1);
		chk("ok", 32'(ok), 32'h1);
		$display("power-up done");
	endtask
	task automatic t_glitch();
		ers_host_model_i.press(4);
		repeat (12) tick();
		chk("glitch", 32'(run), 32'h1);
		$display("glitch done");
	endtask
	task automatic t_ext();
		ers_host_model_i.press(30);
		#1;
		chk("in reset", 32'(core), 32'h1);
		chk("no drive", 32'(oe), 32'h0);
		chk("od value", 32'(lo), 32'h0);
		wait_end();
		chk("cancel", 32'(n >= C && n <= C + 8), 32'h1);
		chk("ready", 32'(ok), 32'h1);
		$display("emergency done");
	endtask
	task automatic t_off();
		@(posedge clk_sys_i);
		power_on_req_i <= 1'h0;
		ers_host_model_i.press(30);
		#1;
		wait_end();
		chk("off", 32'(off), 32'h1);
		chk("stopped", 32'(run), 32'h0);
		$display("power-off done");
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'h0;
		t_power();
		t_glitch();
		t_ext();
		t_off();
		give_verdict();
	end
	// run is a few hundred cycles
	initial begin
		#100us;
		err_count++;
		give_verdict();
	end
endmodule
